// file: design/sgc_device.sv
`timescale 1ns/1ps
module sgc_device
(
	input wire logic ref_clk,
	input wire logic rst,
	sgc_if.dev bus,
	input wire logic [15:0] bitrate_switch,
	input wire logic [15:0] frame_switch,
	input wire logic [3:0] interface_select_switch,
	input wire logic [15:0] partner_in_size,
	input wire logic [15:0] partner_out_size,
	input wire logic [15:0] partner_type,
	input wire logic [15:0] partner_state,
	output logic restart_pulse,
	output logic [15:0] active_bitrate,
	output logic [15:0] active_frame,
	output logic [15:0] active_node,
	output logic [3:0] active_ifmode,
	output logic defaults_active
);
	import sgc_pkg::*;

	logic [15:0] restart_r;
	logic [15:0] node_r;
	logic [15:0] bitrate_r;
	logic [15:0] frame_r;
	logic [15:0] anode_r;
	logic [3:0] ifmode_r;
	logic default_r;
	logic [15:0] rdata_r;
	logic ack_r;
	logic err_r;
	logic restart_pulse_r;
	logic [15:0] wval;
	logic [15:0] rval;
	logic [15:0] rdata_nxt;
	logic [15:0] bitrate_nxt;
	logic [15:0] frame_nxt;
	logic [15:0] anode_nxt;
	logic [3:0] ifmode_nxt;
	logic mapped;
	logic in_range;
	logic wr_req;
	logic rd_req;
	logic hit_restart;
	logic hit_node;
	logic node_ok;
	logic frame_ok;
	logic ifmode_ok;
	logic do_restart;
	logic use_default;

	// link carries low byte first; store native order
	assign wval = {bus.wdata[7:0], bus.wdata[15:8]};
	assign in_range = bus.num >= SGC_NUM_MIN && bus.num <= SGC_NUM_MAX;
	assign wr_req = bus.req && bus.wr;
	assign rd_req = bus.req && !bus.wr;
	assign hit_restart = bus.num == SGC_REG_RESTART;
	assign hit_node = bus.num == SGC_REG_NODE;
	assign do_restart = wr_req && hit_restart
		&& wval == SGC_RESTART_CMD;
	// switch code zero on bitrate means defaults on this variant
	assign use_default = bitrate_switch == SGC_ZERO
		|| bitrate_switch > SGC_BITRATE_MAX;
	assign node_ok = wval >= SGC_NODE_MIN && wval <= SGC_NODE_MAX;
	assign frame_ok = frame_switch <= SGC_FRAME_MAX;
	// code nine is an alias of zero, folded with the out-of-range codes
	assign ifmode_ok = interface_select_switch != SGC_IFMODE_ALIAS
		&& {12'h000, interface_select_switch} <= SGC_IFMODE_MAX;
	assign rdata_nxt = {rval[7:0], rval[15:8]};

	// image of the active set, loaded only by a restart
	always_comb
	begin
		bitrate_nxt = bitrate_switch;
		frame_nxt = frame_switch;
		anode_nxt = node_r;
		if (use_default)
		begin
			bitrate_nxt = SGC_ZERO;
			anode_nxt = SGC_NODE_RST;
		end
		if (!frame_ok)
			frame_nxt = SGC_ZERO;
	end

	// the mode switch is followed each cycle, not held for restart
	always_comb
	begin
		ifmode_nxt = interface_select_switch;
		if (!ifmode_ok)
			ifmode_nxt = SGC_IFMODE_RS232;
	end

	// command register is volatile, cleared by reset
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			restart_r <= SGC_ZERO;
		else if (wr_req && hit_restart)
			restart_r <= wval;
	end

	// pending node id: out-of-range writes dropped
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			node_r <= SGC_NODE_RST;
		else if (wr_req && hit_node && node_ok)
			node_r <= wval;
	end

	// active set captured at restart only; pending writes invisible
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			bitrate_r <= SGC_ZERO;
			frame_r <= SGC_ZERO;
			anode_r <= SGC_NODE_RST;
			default_r <= 1'b0;
		end
		else if (do_restart)
		begin
			bitrate_r <= bitrate_nxt;
			frame_r <= frame_nxt;
			anode_r <= anode_nxt;
			default_r <= use_default;
		end
	end

	// bus has no path to the mode register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ifmode_r <= SGC_IFMODE_RS232;
		else
			ifmode_r <= ifmode_nxt;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			restart_pulse_r <= 1'b0;
		else
			restart_pulse_r <= do_restart;
	end

	always_comb
	begin
		rval = SGC_ZERO;
		mapped = 1'b1;
		case (bus.num)
			SGC_REG_RESTART: rval = restart_r;
			SGC_REG_BITRATE: rval = bitrate_r;
			SGC_REG_FRAME: rval = frame_r;
			SGC_REG_IFMODE: rval = {12'h000, ifmode_r};
			SGC_REG_NODE: rval = node_r;
			SGC_REG_DEFAULT: rval = {15'h0000, default_r};
			SGC_REG_PIN_SIZE: rval = partner_in_size;
			SGC_REG_POUT_SIZE: rval = partner_out_size;
			SGC_REG_PTYPE: rval = partner_type;
			SGC_REG_PSTATE: rval = partner_state;
			default: mapped = 1'b0;
		endcase
	end

	// one answer cycle after each request, for every number
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ack_r <= 1'b0;
		else
			ack_r <= bus.req;
	end

	// unmapped or out-of-range numbers answer with err
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			err_r <= 1'b0;
		else
			err_r <= bus.req && (!mapped || !in_range);
	end

	// read data holds until the next read, so a late look still sees it
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rdata_r <= SGC_ZERO;
		else if (rd_req)
			rdata_r <= rdata_nxt;
	end

	assign bus.ack = ack_r;
	assign bus.err = err_r;
	assign bus.rdata = rdata_r;
	assign restart_pulse = restart_pulse_r;
	assign active_bitrate = bitrate_r;
	assign active_frame = frame_r;
	assign active_node = anode_r;
	assign active_ifmode = ifmode_r;
	assign defaults_active = default_r;
endmodule

// file: design/sgc_pkg.sv
package sgc_pkg;
	localparam int SGC_DW = 16;
	localparam int SGC_AW = 17;
	// register numbers, one-based; 0x10000 needs seventeen bits
	localparam logic [16:0] SGC_NUM_MIN = 17'h00001;
	localparam logic [16:0] SGC_NUM_MAX = 17'h10000;
	localparam logic [16:0] SGC_REG_RESTART = 17'h01000;
	localparam logic [16:0] SGC_REG_BITRATE = 17'h01001;
	localparam logic [16:0] SGC_REG_FRAME = 17'h01002;
	localparam logic [16:0] SGC_REG_IFMODE = 17'h01003;
	localparam logic [16:0] SGC_REG_NODE = 17'h01004;
	localparam logic [16:0] SGC_REG_DEFAULT = 17'h01005;
	localparam logic [16:0] SGC_REG_PIN_SIZE = 17'h01006;
	localparam logic [16:0] SGC_REG_POUT_SIZE = 17'h01007;
	localparam logic [16:0] SGC_REG_PTYPE = 17'h01008;
	localparam logic [16:0] SGC_REG_PSTATE = 17'h01009;
	localparam logic [15:0] SGC_RESTART_CMD = 16'h4b42;
	localparam logic [15:0] SGC_BITRATE_MAX = 16'h0008;
	localparam logic [15:0] SGC_FRAME_MAX = 16'h0005;
	localparam logic [15:0] SGC_IFMODE_MAX = 16'h0009;
	localparam logic [15:0] SGC_NODE_MIN = 16'h0001;
	localparam logic [15:0] SGC_NODE_MAX = 16'h00f9;
	localparam logic [15:0] SGC_NODE_RST = 16'h0001;
	localparam logic [15:0] SGC_DEFAULT_RST = 16'h0000;
	localparam logic [15:0] SGC_ZERO = 16'h0000;
	localparam logic [3:0] SGC_IFMODE_ALIAS = 4'h9;
	localparam logic [3:0] SGC_IFMODE_RS232 = 4'h0;
endpackage

// file: design/sgc_if.sv
`timescale 1ns/1ps
interface sgc_if;
	logic req;
	logic wr;
	logic [16:0] num;
	logic [15:0] wdata;
	logic ack;
	logic err;
	logic [15:0] rdata;
	modport dev
	(
		input req,
		input wr,
		input num,
		input wdata,
		output ack,
		output err,
		output rdata
	);
	modport mst
	(
		output req,
		output wr,
		output num,
		output wdata,
		input ack,
		input err,
		input rdata
	);
endinterface

// file: design/sgc_master.sv
`timescale 1ns/1ps
// configuration-tool side; one access in flight at a time
module sgc_master
(
	input wire logic ref_clk,
	input wire logic rst,
	sgc_if.mst bus,
	input wire logic cmd_valid,
	input wire logic cmd_wr,
	input wire logic [16:0] cmd_num,
	input wire logic [15:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic rsp_err,
	output logic [15:0] rsp_rdata
);
	import sgc_pkg::*;

	typedef enum logic [0:0] {SGC_IDLE, SGC_WAIT} sgc_state_e;
	sgc_state_e state_r;
	logic req_r;
	logic wr_r;
	logic [16:0] num_r;
	logic [15:0] wdata_r;
	logic rsp_valid_r;
	logic rsp_err_r;
	logic [15:0] rsp_rdata_r;

	assign cmd_ready = state_r == SGC_IDLE;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			state_r <= SGC_IDLE;
		else
			case (state_r)
				SGC_IDLE: if (cmd_valid) state_r <= SGC_WAIT;
				SGC_WAIT: if (bus.ack) state_r <= SGC_IDLE;
				default: state_r <= SGC_IDLE;
			endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			req_r <= 1'b0;
			wr_r <= 1'b0;
			num_r <= 17'h00000;
			wdata_r <= SGC_ZERO;
		end
		else if (state_r == SGC_IDLE && cmd_valid)
		begin
			req_r <= 1'b1;
			wr_r <= cmd_wr;
			num_r <= cmd_num;
			// send low byte first on the link
			wdata_r <= {cmd_wdata[7:0], cmd_wdata[15:8]};
		end
		else
			req_r <= 1'b0;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rsp_valid_r <= 1'b0;
			rsp_err_r <= 1'b0;
			rsp_rdata_r <= SGC_ZERO;
		end
		else
		begin
			rsp_valid_r <= state_r == SGC_WAIT && bus.ack;
			if (state_r == SGC_WAIT && bus.ack)
			begin
				rsp_err_r <= bus.err;
				rsp_rdata_r <= {bus.rdata[7:0], bus.rdata[15:8]};
			end
		end
	end

	assign bus.req = req_r;
	assign bus.wr = wr_r;
	assign bus.num = num_r;
	assign bus.wdata = wdata_r;
	assign rsp_valid = rsp_valid_r;
	assign rsp_err = rsp_err_r;
	assign rsp_rdata = rsp_rdata_r;
endmodule

// file: verification/sgc_link_sva.sv
`timescale 1ns/1ps
module sgc_link_sva
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic req,
	input wire logic wr,
	input wire logic [16:0] num,
	input wire logic [15:0] wdata,
	input wire logic ack,
	input wire logic err,
	input wire logic [15:0] rdata
);
	logic rd_r;
	logic req_r;
	logic [16:0] num_r;
	// read data is judged a cycle late, with the number it answers
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			{rd_r, req_r} <= 2'b00;
		else
			{rd_r, req_r} <= {req && !wr, req};
	always_ff @(posedge ref_clk)
		num_r <= num;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_ack_follows: assert property (req |=> ack)
		else $error("no ack after request");
	a_ack_caused: assert property (ack |-> req_r)
		else $error("ack without request");
	a_err_unmapped: assert property
		(req && (num < 17'h01000 || num > 17'h01009) |=> err)
		else $error("unmapped access not refused");
	a_err_mapped: assert property
		(req && num >= 17'h01000 && num <= 17'h01009 |=> !err)
		else $error("mapped access refused");
	a_rdata_held: assert property (!(req && !wr) |=> $stable(rdata))
		else $error("read data moved without read");
	a_bitrate_range: assert property
		(rd_r && num_r == 17'h01001 |-> rdata[7:0] == 8'h00 &&
		rdata[15:8] <= 8'h08) else $error("bitrate code bad");
	a_frame_range: assert property
		(rd_r && num_r == 17'h01002 |-> rdata[7:0] == 8'h00 &&
		rdata[15:8] <= 8'h05) else $error("frame code bad");
	a_ifmode_range: assert property
		(rd_r && num_r == 17'h01003 |-> rdata[7:0] == 8'h00 &&
		rdata[15:8] <= 8'h08) else $error("mode code bad");
	a_default_flag: assert property
		(rd_r && num_r == 17'h01005 |-> rdata[7:0] == 8'h00 &&
		rdata[15:8] <= 8'h01) else $error("default flag bad");
endmodule

// file: verification/serial_gateway_config_registers_tb.sv
`timescale 1ns/1ps
module serial_gateway_config_registers_tb;
	import sgc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0, cmd_wr = 1'b0, cmd_ready, rsp_valid, rsp_err;
	logic [16:0] cmd_num = 17'h00000;
	logic [15:0] cmd_wdata = 16'h0000, rsp_rdata, act_br, act_fr, act_node;
	logic [15:0] br_sw = 16'h0000, fr_sw = 16'h0000, p [4] = '{4{16'h0}};
	logic [3:0] mode_sw = 4'h0, act_mode;
	logic restart_pulse, act_def;
	int failures = 0, n_tests = 0, pulses = 0, i, j;
	int m_rs = 0, m_node = 1, m_an = 1, m_br = 0, m_fr = 0, m_def = 0;
	int m_pul = 0;
	sgc_if link();
	sgc_device sgc_device_inst(.ref_clk(ref_clk), .rst(rst), .bus(link),
		.bitrate_switch(br_sw), .frame_switch(fr_sw),
		.interface_select_switch(mode_sw), .partner_in_size(p[0]),
		.partner_out_size(p[1]), .partner_type(p[2]), .partner_state(p[3]),
		.restart_pulse(restart_pulse), .active_bitrate(act_br),
		.active_frame(act_fr), .active_node(act_node),
		.active_ifmode(act_mode), .defaults_active(act_def));
	sgc_master sgc_master_inst(.ref_clk(ref_clk), .rst(rst), .bus(link),
		.cmd_valid(cmd_valid), .cmd_wr(cmd_wr), .cmd_num(cmd_num),
		.cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata));
	sgc_link_sva sgc_link_sva_inst(.ref_clk(ref_clk), .rst(rst),
		.req(link.req), .wr(link.wr), .num(link.num), .wdata(link.wdata),
		.ack(link.ack), .err(link.err), .rdata(link.rdata));
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
		if (restart_pulse === 1'b1)
			pulses++;
	task automatic chk(input logic [15:0] g, input int e);
		n_tests++;
		if (g !== 16'(e))
		begin
			failures++;
			$display("wrong value at %0t got %h exp %h", $time, g, 16'(e));
		end
	endtask
	task automatic xfer(input logic w, input logic [16:0] n,
		input logic [15:0] d);
		int e;
		int k;
		logic bad;
		bad = n < 17'h01000 || n > 17'h01009;
		case (n)
			17'h01000: e = m_rs;
			17'h01001: e = m_br;
			17'h01002: e = m_fr;
			17'h01003: e = mode_sw > 8 ? 0 : mode_sw;
			17'h01004: e = m_node;
			17'h01005: e = m_def;
			default: e = bad ? 0 : p[n - 17'h01006];
		endcase
		if (w && n == 17'h01000)
			m_rs = d;
		if (w && n == 17'h01000 && d == 16'h4b42)
		begin
			m_def = br_sw == 0 || br_sw > 8;
			m_br = m_def ? 0 : br_sw;
			m_fr = fr_sw > 5 ? 0 : fr_sw;
			m_an = m_def ? 1 : m_node;
			m_pul++;
		end
		if (w && n == 17'h01004 && d >= 1 && d <= 249)
			m_node = d;
		{cmd_valid, cmd_wr, cmd_num, cmd_wdata} = {1'b1, w, n, d};
		@(posedge ref_clk);
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		chk(cmd_ready, 0);
		k = 0;
		while (rsp_valid !== 1'b1 && k < 9)
		begin
			@(negedge ref_clk);
			k++;
		end
		chk(cmd_ready, 1);
		chk(rsp_valid, 1);
		chk(rsp_err, bad);
		if (!w && !bad)
			chk(rsp_rdata, e);
		chk(act_br, m_br);
		chk(act_fr, m_fr);
		chk(act_node, m_an);
		chk(act_def, m_def);
		chk(act_mode, mode_sw > 8 ? 0 : mode_sw);
		chk(pulses, m_pul);
	endtask
	task automatic end_sim;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#100000;
		failures++;
		end_sim;
	end
	initial
	begin
		void'($urandom(32'hb629f9e4));
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		for (i = 0; i < 12; i++)
		begin
			{br_sw, fr_sw, mode_sw} = {16'(i), 16'(i), 4'(i)};
			for (j = 0; j < 4; j++)
				p[j] = 16'($urandom);
			for (j = 'h0fff; j <= 'h100a; j++)
				xfer(0, 17'(j), 16'h0);
			for (j = 'h1001; j <= 'h1009; j++)
				if (j != 'h1004)
					xfer(1, 17'(j), 16'($urandom));
			xfer(1, SGC_REG_NODE, i ? 16'($urandom_range(0, 255)) : 249);
			xfer(1, 17'h10000, SGC_RESTART_CMD);
			xfer(1, SGC_REG_RESTART, i % 3 ? SGC_RESTART_CMD : 16'(i));
		end
		end_sim;
	end
endmodule
